// ---- hw/stb_defs.svh ----
// Constants of the torque-limit selector and the enable/brake sequencer.
// Assumes a 40 MHz control clock; all times are counted on a 1 ms tick.
`ifndef STB_DEFS_SVH
`define STB_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define STB_CLK_HZ       40000000
`define STB_TICK_US      1000
`define STB_TICK_CYC     ((`STB_CLK_HZ / 1000000) * `STB_TICK_US)
`define STB_READY_MS     1500

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define STB_A_SEL        8'h00
`define STB_A_IFWD       8'h04
`define STB_A_IREV       8'h08
`define STB_A_EFWD       8'h0c
`define STB_A_EREV       8'h10
`define STB_A_TRIAL      8'h14
`define STB_A_PRESET0    8'h18
`define STB_A_PRESET3    8'h24
`define STB_A_STILL      8'h28
`define STB_A_HOLD       8'h2c
`define STB_A_WAIT       8'h30
`define STB_A_RUNSPD     8'h34
`define STB_A_RELDLY     8'h38
`define STB_A_STATUS     8'h3c
`define STB_A_LIMITS     8'h40

// ----------------------------------------------------------------------------
// Reset values and accepted ranges
// ----------------------------------------------------------------------------
`define STB_D_IFWD       10'h12c
`define STB_D_IREV       10'h12c
`define STB_D_EXT        10'h064
`define STB_D_TRIAL      10'h064
`define STB_D_PRESET     10'h064
`define STB_D_STILL      12'h005
`define STB_D_HOLD       11'h096
`define STB_D_WAIT       11'h1f4
`define STB_D_RUNSPD     12'h064
`define STB_D_RELDLY     11'h000
`define STB_SEL_MAX      16'h0002
`define STB_LIM_MAX      16'h01f4
`define STB_TRIAL_MAX    16'h012c
`define STB_STILL_MAX    16'h03e8
`define STB_TIME_MAX     16'h07d0
`define STB_RUNSPD_MAX   16'h0bb8
`define STB_RELDLY_MAX   16'h03e8

// ----------------------------------------------------------------------------
// Synchroniser bit positions
// ----------------------------------------------------------------------------
`define STB_S_FSEL       0
`define STB_S_RSEL       1
`define STB_S_PLO        2
`define STB_S_PHI        3
`define STB_S_EN         4
`define STB_S_MAIN       5
`define STB_S_ALARM      6
`define STB_S_TRIAL      7

`endif

// ---- hw/stb_pkg.sv ----
// Types of the torque-limit selector and enable/brake sequencer.
// Widths are fixed; the module checks its parameters against them.
package stb_pkg;

  typedef enum logic [2:0] {
    ST_OFF        = 3'b000,
    ST_WAIT_RDY   = 3'b001,
    ST_READY      = 3'b010,
    ST_REL_DLY    = 3'b011,
    ST_RUN        = 3'b100,
    ST_STOP_HOLD  = 3'b101,
    ST_STOP_COAST = 3'b110
  } stb_state_t;

  typedef struct packed {
    logic [7:0]       sync1;
    logic [7:0]       sync2;
    logic [1:0]       sel;
    logic [9:0]       ifwd;
    logic [9:0]       irev;
    logic [9:0]       efwd;
    logic [9:0]       erev;
    logic [9:0]       trial;
    logic [3:0][9:0]  preset;
    logic [11:0]      still_spd;
    logic [11:0]      run_spd;
    logic [10:0]      hold_ms;
    logic [10:0]      wait_ms;
    logic [10:0]      rel_ms;
    stb_state_t       state;
    logic [15:0]      tick_cnt;
    logic [10:0]      ms_cnt;
    logic [9:0]       fwd_lim;
    logic [9:0]       rev_mag;
    logic             rdy;
    logic             pwr;
    logic             brake_release_out;
    logic [15:0]      rdata;
  } stb_regs_t;

endpackage

// ---- hw/stb_servo_ctrl.sv ----
// Torque-limit selector plus power-on, enable and holding-brake sequencer.
// Assumes pins arrive asynchronously; speed and analog torque come from
// logic on clock_i. Registers sit on a plain strobe port, read data +1.
//
// Function
// RULE1: Mode 0 forward limit: internal if select off, external if on.
// RULE2: Mode 0 reverse limit: internal if select off, external if on.
// RULE3: Mode 1 adds a limit of the analog command magnitude, both directions.
// RULE4: Mode 2 adds the selected preset torque as a limit, both directions.
// RULE5: With several limits active the smallest magnitude wins.
// RULE6: Internal forward and reverse limits are always enforced.
// RULE7: Output limits never exceed the system maximum torque.
// RULE8: Preset selects hi,lo: 00 preset1, 01 preset2, 10 preset3, 11 preset4.
// RULE9: Internal limits range 0..500 and -500..0, defaults 300 and -300.
// RULE10: External limits default 100 and -100, ranges as the internal ones.
// RULE11: Trial running limits torque by its own setting 0..300, default 100.
// RULE12: Servo-ready stays off without main supply.
// RULE13: Servo-ready about 1.5 s after main power; enable honoured only then.
// RULE14: Enable switches the power stage on and enters running.
// RULE15: Enable off or alarm switches the power stage off.
// RULE16: Stationary means speed below standstill threshold, 0..1000, default 5.
// RULE17: Off while still: brake at once, power off after hold delay, 150 ms.
// RULE18: On enable: power first, brake release after release delay, 0 ms.
// RULE19: Off while running: power off, brake after 500 ms or below 100 r/min.
// RULE20: Brake output high releases, low engages the brake.
// RULE21: Control supply comes up with or before main supply.
// RULE22: Speeds compared by magnitude; delays counted on a 1 ms tick.
`timescale 1ns/10ps
`include "stb_defs.svh"

module stb_servo_ctrl
  import stb_pkg::*;
#(
  parameter int TICK_CYCLES = `STB_TICK_CYC,
  parameter int READY_MS    = `STB_READY_MS,
  parameter int MAX_TQ      = 300
) (
  // Clock and reset
  input  wire logic               clock_i,
  input  wire logic               rstn_i,
  // Register port
  input  wire logic [7:0]         addr_i,
  input  wire logic [15:0]        wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [15:0]        rdata_o,
  // Asynchronous digital inputs
  input  wire logic               main_power_ok_i,
  input  wire logic               alarm_i,
  input  wire logic               servo_enable_in_i,
  input  wire logic               fwd_external_limit_sel_i,
  input  wire logic               rev_external_limit_sel_i,
  input  wire logic               torque_preset_sel_lo_i,
  input  wire logic               torque_preset_sel_hi_i,
  input  wire logic               trial_run_i,
  // Same-clock measurements, percent and r/min
  input  wire logic signed [10:0] analog_torque_cmd_i,
  input  wire logic signed [15:0] motor_speed_i,
  // Limits and sequencer outputs
  output logic      [9:0]         fwd_torque_limit_o,
  output logic signed [10:0]      rev_torque_limit_o,
  output logic                    servo_ready_o,
  output logic                    power_stage_on_o,
  output logic                    brake_release_out_o
);

  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_chk_tick
    $error("TICK_CYCLES out of range");
  end
  if (READY_MS < 1 || READY_MS > 2047) begin : g_chk_rdy
    $error("READY_MS out of range");
  end
  if (MAX_TQ < 0 || MAX_TQ > 500) begin : g_chk_max
    $error("MAX_TQ out of range");
  end

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [10:0] RDY_MS    = 11'(READY_MS);
  localparam logic [9:0]  MAX_LIM   = 10'(MAX_TQ);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [9:0] tq_min(input logic [9:0] a, input logic [9:0] b);
    return (a < b) ? a : b;
  endfunction

  // Clamp a signed write value into 0..hi
  function automatic logic [15:0] sat(input logic signed [16:0] v,
                                      input logic [15:0] hi);
    if (v < 0) begin
      return 16'h0000;
    end else if (v > $signed({1'b0, hi})) begin
      return hi;
    end
    return v[15:0];
  endfunction

  function automatic logic [9:0] tq_mag(input logic signed [10:0] v);
    logic [10:0] a;
    a = v[10] ? 11'(-v) : 11'(v);
    return (a > 11'(`STB_LIM_MAX)) ? 10'(`STB_LIM_MAX) : a[9:0];
  endfunction

  function automatic logic [15:0] spd_mag(input logic signed [15:0] v);
    logic [16:0] a;
    a = v[15] ? 17'(-$signed({v[15], v})) : 17'({1'b0, v});
    return a[16] ? 16'hffff : a[15:0];
  endfunction

  stb_regs_t st_ff;
  stb_regs_t nxt_st;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    logic signed [16:0] wv;
    logic               tick;
    logic               en;
    logic               alarm;
    logic               still;
    logic               slow;
    logic [9:0]         basic_f;
    logic [9:0]         basic_r;
    logic [9:0]         extra;
    logic [9:0]         f;
    logic [9:0]         r;
    logic [15:0]        spd;
    wv      = $signed({wdata_i[15], wdata_i});
    tick    = (st_ff.tick_cnt == TICK_LAST); // RULE22
    en      = st_ff.sync2[`STB_S_EN];
    alarm   = st_ff.sync2[`STB_S_ALARM];
    spd     = spd_mag(motor_speed_i); // RULE22
    still   = spd < {4'h0, st_ff.still_spd}; // RULE16
    slow    = spd < {4'h0, st_ff.run_spd};
    basic_f = 10'h000;
    basic_r = 10'h000;
    extra   = 10'h000;
    f       = 10'h000;
    r       = 10'h000;
    nxt_st  = st_ff;
    nxt_st.sync1 = {trial_run_i, alarm_i, main_power_ok_i, servo_enable_in_i,
                    torque_preset_sel_hi_i, torque_preset_sel_lo_i,
                    rev_external_limit_sel_i, fwd_external_limit_sel_i};
    nxt_st.sync2 = st_ff.sync1;

    nxt_st.tick_cnt = tick ? 16'h0000 : st_ff.tick_cnt + 16'h0001;

    // Writes clamp to the accepted range rather than being refused
    if (wr_i) begin
      if (addr_i == `STB_A_SEL) begin
        nxt_st.sel = 2'(sat(wv, `STB_SEL_MAX));
      end else if (addr_i == `STB_A_IFWD) begin
        nxt_st.ifwd = 10'(sat(wv, `STB_LIM_MAX)); // RULE9
      end else if (addr_i == `STB_A_IREV) begin
        nxt_st.irev = 10'(sat(-wv, `STB_LIM_MAX)); // RULE9
      end else if (addr_i == `STB_A_EFWD) begin
        nxt_st.efwd = 10'(sat(wv, `STB_LIM_MAX)); // RULE10
      end else if (addr_i == `STB_A_EREV) begin
        nxt_st.erev = 10'(sat(-wv, `STB_LIM_MAX)); // RULE10
      end else if (addr_i == `STB_A_TRIAL) begin
        nxt_st.trial = 10'(sat(wv, `STB_TRIAL_MAX)); // RULE11
      end else if (addr_i >= `STB_A_PRESET0 && addr_i <= `STB_A_PRESET3
                   && addr_i[1:0] == 2'h0) begin
        nxt_st.preset[2'(addr_i[7:2] - 6'h06)] = 10'(sat(wv, `STB_LIM_MAX));
      end else if (addr_i == `STB_A_STILL) begin
        nxt_st.still_spd = 12'(sat(wv, `STB_STILL_MAX)); // RULE16
      end else if (addr_i == `STB_A_HOLD) begin
        nxt_st.hold_ms = 11'(sat(wv, `STB_TIME_MAX)); // RULE17
      end else if (addr_i == `STB_A_WAIT) begin
        nxt_st.wait_ms = 11'(sat(wv, `STB_TIME_MAX)); // RULE19
      end else if (addr_i == `STB_A_RUNSPD) begin
        nxt_st.run_spd = 12'(sat(wv, `STB_RUNSPD_MAX)); // RULE19
      end else if (addr_i == `STB_A_RELDLY) begin
        nxt_st.rel_ms = 11'(sat(wv, `STB_RELDLY_MAX)); // RULE18
      end
    end

    // Reverse settings read back as negative percent
    nxt_st.rdata = 16'h0000;
    if (rd_i) begin
      if (addr_i == `STB_A_SEL) begin
        nxt_st.rdata = {14'h0000, st_ff.sel};
      end else if (addr_i == `STB_A_IFWD) begin
        nxt_st.rdata = {6'h00, st_ff.ifwd};
      end else if (addr_i == `STB_A_IREV) begin
        nxt_st.rdata = -{6'h00, st_ff.irev};
      end else if (addr_i == `STB_A_EFWD) begin
        nxt_st.rdata = {6'h00, st_ff.efwd};
      end else if (addr_i == `STB_A_EREV) begin
        nxt_st.rdata = -{6'h00, st_ff.erev};
      end else if (addr_i == `STB_A_TRIAL) begin
        nxt_st.rdata = {6'h00, st_ff.trial};
      end else if (addr_i >= `STB_A_PRESET0 && addr_i <= `STB_A_PRESET3
                   && addr_i[1:0] == 2'h0) begin
        nxt_st.rdata = {6'h00, st_ff.preset[2'(addr_i[7:2] - 6'h06)]};
      end else if (addr_i == `STB_A_STILL) begin
        nxt_st.rdata = {4'h0, st_ff.still_spd};
      end else if (addr_i == `STB_A_HOLD) begin
        nxt_st.rdata = {5'h00, st_ff.hold_ms};
      end else if (addr_i == `STB_A_WAIT) begin
        nxt_st.rdata = {5'h00, st_ff.wait_ms};
      end else if (addr_i == `STB_A_RUNSPD) begin
        nxt_st.rdata = {4'h0, st_ff.run_spd};
      end else if (addr_i == `STB_A_RELDLY) begin
        nxt_st.rdata = {5'h00, st_ff.rel_ms};
      end else if (addr_i == `STB_A_STATUS) begin
        nxt_st.rdata = {10'h000, st_ff.brake_release_out, st_ff.pwr, st_ff.rdy, st_ff.state};
      end else if (addr_i == `STB_A_LIMITS) begin
        nxt_st.rdata = {st_ff.fwd_lim[9:2], st_ff.rev_mag[9:2]};
      end
    end

    // ------------------------------------------------------------------------
    // Torque limit selection, all in magnitudes
    // ------------------------------------------------------------------------
    // External limits never loosen the internal ones
    basic_f = st_ff.sync2[`STB_S_FSEL] ? tq_min(st_ff.efwd, st_ff.ifwd) // RULE1
                                       : st_ff.ifwd; // RULE6
    basic_r = st_ff.sync2[`STB_S_RSEL] ? tq_min(st_ff.erev, st_ff.irev) // RULE2
                                       : st_ff.irev; // RULE6
    if (st_ff.sel == 2'h1) begin
      extra = tq_mag(analog_torque_cmd_i); // RULE3
    end else if (st_ff.sel == 2'h2) begin
      extra = st_ff.preset[{st_ff.sync2[`STB_S_PHI], st_ff.sync2[`STB_S_PLO]}]; // RULE4 RULE8
    end else begin
      extra = 10'(`STB_LIM_MAX);
    end
    f = tq_min(basic_f, extra); // RULE5
    r = tq_min(basic_r, extra); // RULE5
    if (st_ff.sync2[`STB_S_TRIAL]) begin
      f = tq_min(f, st_ff.trial); // RULE11
      r = tq_min(r, st_ff.trial); // RULE11
    end
    nxt_st.fwd_lim = tq_min(f, MAX_LIM); // RULE7
    nxt_st.rev_mag = tq_min(r, MAX_LIM); // RULE7

    // ------------------------------------------------------------------------
    // Enable and brake sequencer
    // ------------------------------------------------------------------------
    if (tick && st_ff.ms_cnt != 11'h7ff) begin
      nxt_st.ms_cnt = st_ff.ms_cnt + 11'h001;
    end
    case (st_ff.state)
      ST_OFF: begin
        if (st_ff.sync2[`STB_S_MAIN]) begin
          nxt_st.state = ST_WAIT_RDY;
        end
      end
      ST_WAIT_RDY: begin
        if (st_ff.ms_cnt >= RDY_MS) begin
          nxt_st.state = ST_READY; // RULE13
        end
      end
      ST_READY: begin
        if (en && !alarm) begin
          nxt_st.state = ST_REL_DLY; // RULE14
        end
      end
      ST_REL_DLY, ST_RUN: begin
        // An alarm always cuts current, even at standstill
        if (alarm || (!en && !still)) begin
          nxt_st.state = ST_STOP_COAST; // RULE15 RULE19
        end else if (!en) begin
          nxt_st.state = ST_STOP_HOLD; // RULE17
        end else if (st_ff.state == ST_REL_DLY && st_ff.ms_cnt >= st_ff.rel_ms) begin
          nxt_st.state = ST_RUN; // RULE18
        end
      end
      ST_STOP_HOLD: begin
        if (alarm) begin
          nxt_st.state = ST_STOP_COAST; // RULE15
        end else if (st_ff.ms_cnt >= st_ff.hold_ms) begin
          nxt_st.state = ST_READY; // RULE17
        end
      end
      ST_STOP_COAST: begin
        if (st_ff.ms_cnt >= st_ff.wait_ms || slow) begin
          nxt_st.state = ST_READY; // RULE19
        end
      end
      default: begin
        nxt_st.state = ST_OFF;
      end
    endcase
    if (!st_ff.sync2[`STB_S_MAIN]) begin
      nxt_st.state = ST_OFF; // RULE12
    end
    if (nxt_st.state != st_ff.state) begin
      nxt_st.ms_cnt = 11'h000;
    end

    // Outputs follow the next state so each matches its state flop
    nxt_st.rdy = (nxt_st.state != ST_OFF) && (nxt_st.state != ST_WAIT_RDY); // RULE12
    nxt_st.pwr = (nxt_st.state == ST_REL_DLY) || (nxt_st.state == ST_RUN)
                 || (nxt_st.state == ST_STOP_HOLD); // RULE14
    nxt_st.brake_release_out = (nxt_st.state == ST_RUN) || (nxt_st.state == ST_STOP_COAST); // RULE20
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff           <= '0;
      st_ff.ifwd      <= `STB_D_IFWD;
      st_ff.irev      <= `STB_D_IREV;
      st_ff.efwd      <= `STB_D_EXT;
      st_ff.erev      <= `STB_D_EXT;
      st_ff.trial     <= `STB_D_TRIAL;
      st_ff.preset    <= {4{`STB_D_PRESET}};
      st_ff.still_spd <= `STB_D_STILL;
      st_ff.hold_ms   <= `STB_D_HOLD;
      st_ff.wait_ms   <= `STB_D_WAIT;
      st_ff.run_spd   <= `STB_D_RUNSPD;
      st_ff.rel_ms    <= `STB_D_RELDLY;
      st_ff.state     <= ST_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o             = st_ff.rdata;
  assign fwd_torque_limit_o  = st_ff.fwd_lim;
  assign rev_torque_limit_o  = -$signed({1'b0, st_ff.rev_mag});
  assign servo_ready_o       = st_ff.rdy;
  assign power_stage_on_o    = st_ff.pwr;
  assign brake_release_out_o = st_ff.brake_release_out;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_no_main_ready: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE12
    !st_ff.sync2[`STB_S_MAIN] |=> !servo_ready_o)
    else $error("ready without main supply");

  a_wait_no_power: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE13
    (st_ff.state == ST_WAIT_RDY) |-> !power_stage_on_o && !servo_ready_o)
    else $error("enable honoured before ready");

  a_mode0_fwd_int: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE1
    (st_ff.sel == 2'h0 && !st_ff.sync2[`STB_S_TRIAL] && !st_ff.sync2[`STB_S_FSEL])
    |=> fwd_torque_limit_o == tq_min($past(st_ff.ifwd), MAX_LIM))
    else $error("mode 0 forward limit wrong");

  a_mode0_rev_ext: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE2
    (st_ff.sel == 2'h0 && !st_ff.sync2[`STB_S_TRIAL] && st_ff.sync2[`STB_S_RSEL])
    |=> st_ff.rev_mag == tq_min(tq_min($past(st_ff.erev), $past(st_ff.irev)), MAX_LIM))
    else $error("mode 0 reverse limit wrong");

  a_mode1_analog: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE3
    (st_ff.sel == 2'h1) |=> fwd_torque_limit_o <= tq_mag($past(analog_torque_cmd_i))
    && st_ff.rev_mag <= tq_mag($past(analog_torque_cmd_i)))
    else $error("analog limit not applied");

  a_mode2_preset: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE8
    (st_ff.sel == 2'h2 && st_ff.sync2[`STB_S_PHI] && !st_ff.sync2[`STB_S_PLO])
    |=> fwd_torque_limit_o <= $past(st_ff.preset[2]))
    else $error("preset 3 not applied");

  a_internal_cap: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE6
    ##1 (fwd_torque_limit_o <= $past(st_ff.ifwd) && st_ff.rev_mag <= $past(st_ff.irev)
    && fwd_torque_limit_o <= MAX_LIM))
    else $error("internal or system limit exceeded");

  a_trial_cap: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE11
    st_ff.sync2[`STB_S_TRIAL] |=> fwd_torque_limit_o <= $past(st_ff.trial))
    else $error("trial limit exceeded");

  a_hold_outputs: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE17
    (st_ff.state == ST_RUN && !st_ff.sync2[`STB_S_EN] && !st_ff.sync2[`STB_S_ALARM]
     && st_ff.sync2[`STB_S_MAIN] && spd_mag(motor_speed_i) < {4'h0, st_ff.still_spd})
    |=> !brake_release_out_o && power_stage_on_o)
    else $error("stationary stop sequence wrong");

  a_release_order: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE18
    $rose(brake_release_out_o) && power_stage_on_o |-> $past(power_stage_on_o))
    else $error("brake released before current");

  a_coast_outputs: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE19
    (st_ff.state == ST_STOP_COAST) |-> brake_release_out_o && !power_stage_on_o)
    else $error("running stop sequence wrong");

  a_alarm_cuts: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE15
    (st_ff.sync2[`STB_S_ALARM] && st_ff.state != ST_READY) |=> !power_stage_on_o)
    else $error("alarm did not cut power");

endmodule

// ---- verif/stb_host_model.sv ----
// Host I/O model: main supply switch and brake relay coil.
// Assumes the control supply is up whenever rstn_i is released.
`timescale 1ns/10ps
module stb_host_model (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rstn_i,
  // Bench request and block output
  input  wire logic supply_req_i,
  input  wire logic brake_release_out_i,
  // Toward the block and the relay
  output logic      main_power_ok_o,
  output logic      relay_closed_o
);
  // --------------------------------------------------------------------------
  // Supplies and relay
  // --------------------------------------------------------------------------
  // Main supply may only follow the control supply, never lead it
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      main_power_ok_o <= 1'b0;
    end else begin
      main_power_ok_o <= supply_req_i;
    end
  end
  assign relay_closed_o = brake_release_out_i;
endmodule

// ---- verif/stb_servo_ctrl_bench.sv ----
// Self-checking bench of the torque-limit selector and brake sequencer.
// Assumes TICK_CYCLES 4 and READY_MS 3 so a millisecond is four clocks.
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %0h expected %0h", $time, a, b); end end
module stb_servo_ctrl_bench;
  import stb_pkg::*;
  // --------------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------------
  logic clock_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_prev = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, e;
  logic alarm_i = 1'b0, en = 1'b0, fsel = 1'b0, rsel = 1'b0, plo = 1'b0;
  logic phi = 1'b0, trial = 1'b0, supply = 1'b0;
  logic signed [10:0] ana = 11'sd0;
  logic signed [15:0] spd = 16'sd0;
  logic [15:0] rdata_o, exp_q[$];
  logic [9:0] fwd_o;
  logic signed [10:0] rev_o;
  logic rdy_o, pwr_o, brk_o, main_ok, relay;
  logic [3:0] snap;
  int failures = 0, cmp_count = 0, n, m;
  wire logic [2:0] sq = {brk_o, pwr_o, rdy_o};
  always #12.5 clock_i = ~clock_i;
  stb_servo_ctrl #(.TICK_CYCLES(4), .READY_MS(3), .MAX_TQ(300)) stb_servo_ctrl_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .main_power_ok_i(main_ok),
    .alarm_i(alarm_i), .servo_enable_in_i(en), .fwd_external_limit_sel_i(fsel),
    .rev_external_limit_sel_i(rsel), .torque_preset_sel_lo_i(plo),
    .torque_preset_sel_hi_i(phi), .trial_run_i(trial), .analog_torque_cmd_i(ana),
    .motor_speed_i(spd), .fwd_torque_limit_o(fwd_o), .rev_torque_limit_o(rev_o),
    .servo_ready_o(rdy_o), .power_stage_on_o(pwr_o), .brake_release_out_o(brk_o));
  stb_host_model stb_host_model_inst (.clock_i(clock_i), .rstn_i(rstn_i),
    .supply_req_i(supply), .brake_release_out_i(brk_o), .main_power_ok_o(main_ok),
    .relay_closed_o(relay));
  // --------------------------------------------------------------------------
  // Tasks and read-data watcher
  // --------------------------------------------------------------------------
  // Read data stand only in the cycle after the strobe, so look mid-cycle
  always @(posedge clock_i) rd_prev <= rd_i;
  always @(negedge clock_i) if (rd_prev === 1'b1) begin
    e = exp_q.pop_front();
    `CHK(rdata_o, e)
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i); addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clock_i); wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    @(posedge clock_i); addr_i <= a; rd_i <= 1'b1; exp_q.push_back(x);
    @(posedge clock_i); rd_i <= 1'b0;
  endtask
  // Pins need two sync stages plus the output register
  task automatic lim(input logic [9:0] f, input logic signed [10:0] r);
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    `CHK(fwd_o, f)
    `CHK(rev_o, r)
    @(posedge clock_i);
  endtask
  task automatic wt(input int s, input logic v, input int lm, output int k);
    for (k = 1; k <= lm; k++) begin
      @(negedge clock_i);
      snap = {relay, sq};
      if (sq[s] === v) begin
        @(posedge clock_i);
        return;
      end
    end
    failures++;
    $display("[ERR] %0t wait ran out", $time);
    end_sim();
  endtask
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  logic [7:0]  ra[12] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h28, 8'h2c,
                          8'h30, 8'h34, 8'h38, 8'h44};
  logic [15:0] rv[12] = '{16'h012c, 16'hfed4, 16'h0064, 16'hff9c, 16'h0064, 16'h0064,
                          16'h0005, 16'h0096, 16'h01f4, 16'h0064, 16'h0000, 16'h0000};
  initial begin
    void'($urandom(32'h1c35ec29));
    repeat (10) @(posedge clock_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 12; i++) rd(ra[i], rv[i]);
    lim(10'd300, -11'sd300);
    rd(8'h40, 16'h4b4b);
    fsel <= 1'b1; lim(10'd100, -11'sd300);
    rsel <= 1'b1; lim(10'd100, -11'sd100);
    wr(8'h04, 16'h0032); lim(10'd50, -11'sd100);
    fsel <= 1'b0; rsel <= 1'b0;
    wr(8'h04, 16'h0258); lim(10'd300, -11'sd300);
    rd(8'h04, 16'h01f4);
    trial <= 1'b1; lim(10'd100, -11'sd100);
    trial <= 1'b0; $display("mode 0 test done");
    wr(8'h00, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      m = $urandom_range(500) - 250;
      ana <= 11'(m);
      lim(10'(m < 0 ? -m : m), 11'(m < 0 ? m : -m));
    end
    $display("mode 1 test done");
    for (int i = 0; i < 4; i++) wr(8'h18 + 8'(4 * i), i == 3 ? 16'h0190 : 16'(40 * (i + 1)));
    wr(8'h00, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      {phi, plo} <= 2'(i);
      m = (i == 3) ? 300 : 40 * (i + 1);
      lim(10'(m), 11'(-m));
    end
    $display("mode 2 test done");
    wr(8'h2c, 16'h0002);
    wr(8'h30, 16'h0014);
    en <= 1'b1; repeat (20) @(posedge clock_i); @(negedge clock_i);
    `CHK(sq, 3'b000)
    @(posedge clock_i); en <= 1'b0; supply <= 1'b1;
    wt(0, 1'b1, 40, n); `CHK(n >= 8, 1'b1)
    rd(8'h3c, 16'h000a);
    en <= 1'b1; wt(1, 1'b1, 5, n); `CHK(snap[2], 1'b0)
    wt(2, 1'b1, 3, n); `CHK(snap[3], 1'b1)
    en <= 1'b0; wt(2, 1'b0, 5, n); `CHK(snap[1], 1'b1)
    wt(1, 1'b0, 16, n); `CHK(n >= 4, 1'b1)
    $display("stationary test done");
    for (int j = 0; j < 2; j++) begin
      spd <= -16'sd500; repeat (10) @(posedge clock_i);
      en <= 1'b1; wt(2, 1'b1, 10, n);
      en <= 1'b0; wt(1, 1'b0, 5, n); `CHK(snap[2], 1'b1)
      if (j == 0) begin
        repeat (10) @(posedge clock_i);
        spd <= -16'sd50; wt(2, 1'b0, 4, n);
      end else begin
        wt(2, 1'b0, 100, n); `CHK(n >= 70 && n <= 90, 1'b1)
      end
    end
    $display("running test done");
    spd <= 16'sd0; repeat (10) @(posedge clock_i);
    en <= 1'b1; wt(2, 1'b1, 10, n);
    alarm_i <= 1'b1; wt(1, 1'b0, 5, n);
    alarm_i <= 1'b0; en <= 1'b0; supply <= 1'b0;
    wt(0, 1'b0, 6, n);
    $display("alarm test done");
    repeat (3) @(posedge clock_i);
    end_sim();
  end
endmodule
